// ==== include/sps_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
`define SPS_OFS_CTRL 2'h0
`define SPS_OFS_STAT 2'h1
`define SPS_OFS_DATA 2'h2
`define SPS_OFS_PDIR 2'h3
`define SPS_STAT_DONE 7
`define SPS_STAT_WRITE_COLLISION_FLAG 6
`define SPS_STAT_DBL 0
`define SPS_PDIR_MOSI 0
`define SPS_PDIR_MISO 1
`define SPS_PDIR_SCK 2
`define SPS_PDIR_SS 3
`define SPS_PDIR_SSLVL 4
`define SPS_CTRL_RST 8'h00
`define SPS_PDIR_RST 5'h00
`define SPS_HALF_R0 7'h02
`define SPS_HALF_R1 7'h08
`define SPS_HALF_R2 7'h20
`define SPS_HALF_R3 7'h40
`define SPS_LAST_EDGE 4'hf
`define SPS_LAST_BIT 3'h7
`endif

// ==== include/sps_pkg.sv ====
// Types shared by the serial port design and its bench
package sps_pkg;
	typedef struct packed {
		logic irq_en;
		logic port_en;
		logic lsb_first;
		logic master;
		logic clock_polarity;
		logic clock_phase;
		logic [1:0] rate;
	} sps_ctrl_type;

	typedef struct packed {
		logic ss_level;
		logic ss_dir;
		logic sck_dir;
		logic miso_dir;
		logic mosi_dir;
	} sps_pdir_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MASTER = 3'b010,
		ST_SLAVE = 3'b100
	} sps_phase_type;

	typedef struct packed {
		logic i;
		logic o;
		logic oe;
	} sps_pin_type;
endpackage

// ==== rtl/sps_port.sv ====
// Byte-wide serial peripheral port, master or slave, with register port
// Function
// R1 - In slave mode slave-select is always an input.
// R2 - Selected slave drives MISO only when its direction bit says output.
// R3 - Deselected slave goes passive, resets shift logic, drops partial byte.
// R4 - Master with slave-select as output: plain output, no effect.
// R5 - Master with slave-select input pulled low drops to slave mode.
// R6 - That fall to slave mode also sets the completion flag.
// R7 - Software must set master-select again after such a fall.
// R8 - Interrupt when completion flag, enable bit and global enable all set.
// R9 - No serial operation unless the port-enable bit is one.
// R10 - Bit-order bit: one sends LSB first, zero MSB first.
// R11 - Master-select bit: one master, zero slave.
// R12 - Polarity bit sets SCK idle level and leading edge direction.
// R13 - Phase bit picks sampling on leading or trailing edge.
// R14 - Master SCK divides clock by 4/16/64/128, halved with double speed.
// R15 - Completion flag set at transfer end; cleared by vector or status-data.
// R16 - Collision flag set on data write mid-transfer; cleared likewise.
// R17 - Status bits 5 to 1 read as zero.
// R18 - Double-speed bit doubles master SCK rate, shortest period two clocks.
// R19 - External master keeps SCK at most a quarter of system clock.
// R20 - Data write starts transmission; data read returns receive buffer.
// R21 - Shift out and latch in on opposite edges; modes 0 to 3.
// R22 - Each transfer is eight bits; master clock stops after eighth.
// R23 - Single buffered send, double buffered receive; unread byte overwritten.
// R24 - Control resets to zero: disabled slave, mode 0, MSB first.
`timescale 1ns/10ps
`default_nettype none
`include "sps_defines.svh"

module sps_port (
	input wire logic CLOCK, // System clock, 125 MHz
	input wire logic RSTN, // Asynchronous reset, active low
	input wire logic [1:0] ADDR, // Register address
	input wire logic [7:0] WDATA, // Write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	output logic [7:0] RDATA, // Read data, cycle after RD
	input wire logic GIE, // Global interrupt enable
	input wire logic IRQ_ACK, // Interrupt vector taken
	output logic IRQ, // Interrupt request
	input wire sps_pkg::sps_pin_type SCK, // Serial clock pin (i in, o/oe out)
	output sps_pkg::sps_pin_type SCK_DRV, // Serial clock drive
	input wire sps_pkg::sps_pin_type MOSI, // Master-out pin
	output sps_pkg::sps_pin_type MOSI_DRV, // Master-out drive
	input wire sps_pkg::sps_pin_type MISO, // Master-in pin
	output sps_pkg::sps_pin_type MISO_DRV, // Master-in drive
	input wire sps_pkg::sps_pin_type SS, // Slave-select pin
	output sps_pkg::sps_pin_type SS_DRV // Slave-select drive
);
	import sps_pkg::*;

	typedef struct packed {
		sps_ctrl_type ctrl;
		sps_pdir_type pdir;
		logic dbl;
		logic done;
		logic write_collision_flag;
		logic armed;
		sps_phase_type phase;
		logic [6:0] cnt;
		logic [3:0] edges;
		logic [2:0] bits;
		logic [7:0] tx;
		logic [7:0] rx_sh;
		logic [7:0] rx_buf;
		logic [7:0] rdata;
		logic irq;
		logic sck_m, sck_s, sck_p;
		logic mosi_m, mosi_s;
		logic miso_m, miso_s;
		logic ss_m, ss_s;
		logic sck_o, sck_oe;
		logic mosi_o, mosi_oe;
		logic miso_o, miso_oe;
		logic ss_o, ss_oe;
	} sps_state_type;

	sps_state_type r_ff;
	sps_state_type nxt_r;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [6:0] half_cnt(input logic dbl, input logic [1:0] rate);
		logic [6:0] h;
		h = `SPS_HALF_R0;
		unique case (rate)
			2'h0: h = `SPS_HALF_R0;
			2'h1: h = `SPS_HALF_R1;
			2'h2: h = `SPS_HALF_R2;
			2'h3: h = `SPS_HALF_R3;
		endcase
		half_cnt = dbl ? (h >> 1) : h; // R14 R18
	endfunction

	function automatic logic tx_bit(input logic [7:0] d, input logic [2:0] n, input logic lsb);
		tx_bit = lsb ? d[n] : d[3'h7 - n]; // R10
	endfunction

	function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
		shift_in = lsb ? {b, d[7:1]} : {d[6:0], b}; // R10
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic busy;
		logic ss_low;
		logic edge_now;
		logic leading;
		logic sample;
		logic in_bit;
		logic set_done;
		busy = 1'b0;
		ss_low = 1'b0;
		edge_now = 1'b0;
		leading = 1'b0;
		sample = 1'b0;
		in_bit = 1'b0;
		set_done = 1'b0;
		nxt_r = r_ff;

		// Two-stage synchronisers on every pin input
		nxt_r.sck_m = SCK.i;
		nxt_r.sck_s = r_ff.sck_m;
		nxt_r.sck_p = r_ff.sck_s;
		nxt_r.mosi_m = MOSI.i;
		nxt_r.mosi_s = r_ff.mosi_m;
		nxt_r.miso_m = MISO.i;
		nxt_r.miso_s = r_ff.miso_m;
		nxt_r.ss_m = SS.i;
		nxt_r.ss_s = r_ff.ss_m;
		ss_low = ~r_ff.ss_s;

		busy = (r_ff.phase == ST_MASTER) || (r_ff.phase == ST_SLAVE && r_ff.bits != 3'h0);

		// Register port; read data stand one cycle only
		nxt_r.rdata = 8'h00;
		if (RD) begin
			unique case (ADDR)
				`SPS_OFS_CTRL: nxt_r.rdata = r_ff.ctrl;
				`SPS_OFS_STAT: begin
					nxt_r.rdata = {r_ff.done, r_ff.write_collision_flag, 5'h00, r_ff.dbl}; // R17
					if (r_ff.done || r_ff.write_collision_flag) begin
						nxt_r.armed = 1'b1;
					end
				end
				`SPS_OFS_DATA: nxt_r.rdata = r_ff.rx_buf; // R20
				`SPS_OFS_PDIR: nxt_r.rdata = {3'h0, r_ff.pdir};
			endcase
		end
		// Status read then data access clears both flags
		if ((RD || WR) && ADDR == `SPS_OFS_DATA && r_ff.armed) begin
			nxt_r.done = 1'b0; // R15
			nxt_r.write_collision_flag = 1'b0; // R16
			nxt_r.armed = 1'b0;
		end
		if (IRQ_ACK) begin
			nxt_r.done = 1'b0; // R15
		end
		if (WR) begin
			unique case (ADDR)
				`SPS_OFS_CTRL: nxt_r.ctrl = WDATA; // R7 R11
				`SPS_OFS_STAT: nxt_r.dbl = WDATA[`SPS_STAT_DBL];
				`SPS_OFS_DATA: begin
					if (busy) begin
						nxt_r.write_collision_flag = 1'b1; // R16
					end else begin
						nxt_r.tx = WDATA; // R23
					end
				end
				`SPS_OFS_PDIR: nxt_r.pdir = WDATA[4:0];
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// Serial engine

		if (!r_ff.ctrl.port_en) begin
			nxt_r.phase = ST_IDLE; // R9
			nxt_r.bits = 3'h0;
			nxt_r.sck_o = r_ff.ctrl.clock_polarity;
		end else if (r_ff.ctrl.master && !r_ff.pdir.ss_dir && ss_low) begin
			// Another master has selected us
			nxt_r.ctrl.master = 1'b0; // R5
			nxt_r.phase = ST_IDLE;
			nxt_r.bits = 3'h0;
			set_done = 1'b1; // R6
		end else if (r_ff.ctrl.master) begin
			nxt_r.sck_o = r_ff.ctrl.clock_polarity; // R12
			if (r_ff.phase != ST_MASTER) begin
				nxt_r.phase = ST_IDLE;
				nxt_r.bits = 3'h0;
				if (WR && ADDR == `SPS_OFS_DATA) begin
					nxt_r.phase = ST_MASTER; // R20
					nxt_r.cnt = 7'(half_cnt(r_ff.dbl, r_ff.ctrl.rate) - 7'h01);
					nxt_r.edges = 4'h0;
					nxt_r.mosi_o = tx_bit(WDATA, 3'h0, r_ff.ctrl.lsb_first);
				end
			end else if (r_ff.cnt != 7'h00) begin
				nxt_r.sck_o = r_ff.sck_o;
				nxt_r.cnt = r_ff.cnt - 7'h01;
			end else begin
				// Edge numbers: even are leading, odd trailing
				nxt_r.sck_o = ~r_ff.sck_o; // R14
				nxt_r.cnt = 7'(half_cnt(r_ff.dbl, r_ff.ctrl.rate) - 7'h01);
				nxt_r.edges = r_ff.edges + 4'h1;
				edge_now = 1'b1;
				leading = ~r_ff.edges[0];
				in_bit = r_ff.miso_s;
				if (r_ff.edges == `SPS_LAST_EDGE) begin
					nxt_r.phase = ST_IDLE; // R22
					nxt_r.sck_o = r_ff.ctrl.clock_polarity;
				end
			end
		end else begin
			// Slave: select gates everything, deselect wipes the shifter
			nxt_r.sck_o = r_ff.ctrl.clock_polarity;
			if (ss_low) begin
				nxt_r.phase = ST_SLAVE; // R2
				if (r_ff.phase == ST_SLAVE && r_ff.sck_s != r_ff.sck_p) begin
					edge_now = 1'b1;
					leading = r_ff.sck_s != r_ff.ctrl.clock_polarity; // R12
					in_bit = r_ff.mosi_s;
				end
			end else begin
				nxt_r.phase = ST_IDLE; // R3
				nxt_r.bits = 3'h0;
				nxt_r.rx_sh = 8'h00;
			end
		end

		sample = edge_now && (leading ^ r_ff.ctrl.clock_phase); // R13 R21
		if (sample) begin
			nxt_r.rx_sh = shift_in(r_ff.rx_sh, in_bit, r_ff.ctrl.lsb_first);
			nxt_r.bits = r_ff.bits + 3'h1;
			if (r_ff.phase == ST_SLAVE && r_ff.bits == `SPS_LAST_BIT) begin
				nxt_r.rx_buf = nxt_r.rx_sh; // R23
				set_done = 1'b1; // R15
			end
		end else if (edge_now) begin
			// Setup edge: present the bit now due
			if (r_ff.ctrl.master) begin
				nxt_r.mosi_o = tx_bit(r_ff.tx, r_ff.bits, r_ff.ctrl.lsb_first);
			end else begin
				nxt_r.miso_o = tx_bit(r_ff.tx, r_ff.bits, r_ff.ctrl.lsb_first);
			end
		end else if (nxt_r.phase == ST_SLAVE && nxt_r.bits == 3'h0) begin
			// Phase 0 needs bit 0 out before the first edge
			nxt_r.miso_o = tx_bit(nxt_r.tx, 3'h0, r_ff.ctrl.lsb_first);
		end
		if (r_ff.phase == ST_MASTER && edge_now && r_ff.edges == `SPS_LAST_EDGE) begin
			nxt_r.rx_buf = nxt_r.rx_sh; // R22 R23
			nxt_r.bits = 3'h0;
			set_done = 1'b1; // R15
		end
		// Set wins over any clear in the same cycle
		if (set_done) begin
			nxt_r.done = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////
		// Pin drives

		nxt_r.irq = nxt_r.done && nxt_r.ctrl.irq_en && GIE; // R8
		nxt_r.ss_o = nxt_r.pdir.ss_level;
		nxt_r.ss_oe = nxt_r.ctrl.port_en && nxt_r.ctrl.master && nxt_r.pdir.ss_dir; // R1 R4
		if (nxt_r.ctrl.port_en && nxt_r.ctrl.master) begin
			nxt_r.mosi_oe = nxt_r.pdir.mosi_dir;
			nxt_r.sck_oe = nxt_r.pdir.sck_dir;
			nxt_r.miso_oe = 1'b0;
		end else begin
			nxt_r.mosi_oe = 1'b0; // R5
			nxt_r.sck_oe = 1'b0;
			nxt_r.miso_oe = nxt_r.ctrl.port_en && nxt_r.pdir.miso_dir
				&& nxt_r.phase == ST_SLAVE; // R2 R3
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			r_ff <= '0;
			r_ff.ctrl <= `SPS_CTRL_RST; // R24
			r_ff.pdir <= `SPS_PDIR_RST;
			r_ff.phase <= ST_IDLE;
			r_ff.ss_m <= 1'b1;
			r_ff.ss_s <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Limitation: master samples MISO through the synchroniser, so at /4 and /2
	// the far slave must hold data a cycle past the setup edge.
	assign RDATA = r_ff.rdata;
	assign IRQ = r_ff.irq;
	assign SCK_DRV = '{i: 1'b0, o: r_ff.sck_o, oe: r_ff.sck_oe};
	assign MOSI_DRV = '{i: 1'b0, o: r_ff.mosi_o, oe: r_ff.mosi_oe};
	assign MISO_DRV = '{i: 1'b0, o: r_ff.miso_o, oe: r_ff.miso_oe};
	assign SS_DRV = '{i: 1'b0, o: r_ff.ss_o, oe: r_ff.ss_oe};
endmodule
`default_nettype wire

// ==== verification/sps_chk.sv ====
// Assertions on the serial port pins and register port
`timescale 1ns/10ps
`default_nettype none
module sps_chk (
	input wire logic CLOCK, // Clock
	input wire logic RSTN, // Reset
	input wire logic [1:0] ADDR, // Address
	input wire logic RD, // Read
	input wire logic [7:0] RDATA, // Data
	input wire logic GIE, // Enable
	input wire logic IRQ, // Request
	input wire sps_pkg::sps_pin_type SS, // Select
	input wire sps_pkg::sps_pin_type SS_DRV, // Select out
	input wire sps_pkg::sps_pin_type SCK_DRV, // Clock out
	input wire sps_pkg::sps_pin_type MISO_DRV // Data out
);
	import sps_pkg::*;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RSTN);
	// Synchroniser lag lets the drive trail the pin
	sequence s_sel;
		!SS.i || !$past(SS.i) || !$past(SS.i, 2) || !$past(SS.i, 3);
	endsequence
	sequence s_fight;
		(SCK_DRV.oe && !SS_DRV.oe && !SS.i) [*5];
	endsequence
	rd_win_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("stray data");
	stat_resv_a: assert property (RD && ADDR == 2'h1 |=> RDATA[5:1] == 5'h00)
		else $error("reserved set");
	dir_width_a: assert property (RD && ADDR == 2'h3 |=> RDATA[7:5] == 3'h0)
		else $error("dir width");
	irq_gate_a: assert property (IRQ |-> $past(GIE)) else $error("irq ungated");
	miso_sel_a: assert property (MISO_DRV.oe |-> s_sel) else $error("miso unselected");
	ss_input_a: assert property (MISO_DRV.oe |-> !SS_DRV.oe) else $error("ss driven");
	role_excl_a: assert property (SCK_DRV.oe |-> !MISO_DRV.oe) else $error("two roles");
	fall_back_a: assert property (s_fight |=> !SCK_DRV.oe) else $error("no fallback");
endmodule
bind sps_port sps_chk u_chk (.CLOCK, .RSTN, .ADDR, .RD, .RDATA, .GIE, .IRQ, .SS, .SS_DRV,
	.SCK_DRV, .MISO_DRV);
`default_nettype wire

// ==== verification/sps_slave_model.sv ====
// Behavioural slave device on the serial link
`timescale 1ns/10ps
`default_nettype none
module sps_slave_model (
	input wire logic sck, // Clock
	input wire logic ss_n, // Select
	input wire logic mosi, // In
	output logic miso, // Out
	input wire logic [1:0] mode, // Mode
	input wire logic lsb, // Order
	input wire logic [7:0] tx, // Reply
	output logic [7:0] rx // Seen
);
	int k = 0;
	initial miso = 1'b0;
	initial rx = 8'h00;
	always @(ss_n) begin
		k = mode[0] ? 0 : 1;
		// Released line shows the inverse of its last level
		miso = ss_n ? ~miso : (lsb ? tx[0] : tx[7]);
	end
	always @(sck) begin
		if (!ss_n && ((sck != mode[1]) != mode[0])) begin
			rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		end else if (!ss_n && k < 8) begin
			miso = lsb ? tx[k] : tx[7 - k];
			k++;
		end
	end
endmodule
`default_nettype wire

// ==== verification/sps_port_tb.sv ====
// Self-checking bench of the serial port
`timescale 1ns/10ps
`default_nettype none
module sps_port_tb;
	import sps_pkg::*;
	logic clock = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, gie = 1'b0, ack = 1'b0, irq;
	logic e_sck = 1'b0, e_mosi = 1'b0, e_ss = 1'b1, s_miso, l_sck = 1'b0, lsb = 1'b0;
	logic [1:0] addr = 2'h0, mode = 2'h0;
	logic [7:0] wdata = 8'h00, rdata, got, s_tx = 8'h00, s_rx, sm = 8'h00;
	logic [16:0] seed = 17'h1_5278;
	logic [7:0] exp_q[$];
	sps_pin_type sck_d, mosi_d, miso_d, ss_d, sck_p, mosi_p, miso_p, ss_p;
	int errors = 0, total_checks = 0, gap = 0, gmin, gmax, tog = 0;
	int div[4] = '{4, 16, 64, 128};
	assign sck_p = '{sck_d.oe ? sck_d.o : e_sck, 1'b0, 1'b0};
	assign mosi_p = '{mosi_d.oe ? mosi_d.o : e_mosi, 1'b0, 1'b0};
	assign miso_p = '{miso_d.oe ? miso_d.o : s_miso, 1'b0, 1'b0};
	assign ss_p = '{ss_d.oe ? ss_d.o : e_ss, 1'b0, 1'b0};
	sps_port DUT (.CLOCK(clock), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .GIE(gie), .IRQ_ACK(ack), .IRQ(irq), .SCK(sck_p), .SCK_DRV(sck_d),
		.MOSI(mosi_p), .MOSI_DRV(mosi_d), .MISO(miso_p), .MISO_DRV(miso_d), .SS(ss_p),
		.SS_DRV(ss_d));
	sps_slave_model u_slv (.sck(sck_p.i), .ss_n(ss_p.i), .mosi(mosi_p.i), .miso(s_miso),
		.mode(mode), .lsb(lsb), .tx(s_tx), .rx(s_rx));
	initial forever #4 clock = ~clock;
	initial begin
		#200000;
		errors++;
		report_and_stop;
	end
	// Half-period meter; the first toggle is skipped
	always @(negedge clock) begin
		gap++;
		if (sck_d.o !== l_sck) begin
			tog++;
			if (tog > 1 && gap < gmin) gmin = gap;
			if (tog > 1 && gap > gmax) gmax = gap;
			gap = 0;
		end
		l_sck = sck_d.o;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [16:0] lfsr_step(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [1:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		// Data stand for the whole next cycle; take them at its closing edge
		@(posedge clock);
		got = rdata;
	endtask
	task automatic send(input logic [7:0] v, input int n);
		for (int b = 0; b < n; b++) begin
			e_mosi <= v[7 - b];
			repeat (4) @(posedge clock);
			// Slave reply has settled before our rising edge
			sm = {sm[6:0], miso_p.i};
			e_sck <= 1'b1;
			repeat (4) @(posedge clock);
			e_sck <= 1'b0;
		end
		repeat (6) @(posedge clock);
	endtask
	task automatic xfer(input int i);
		logic [7:0] d;
		int h;
		h = div[i % 4] >> (i / 4 + 1);
		seed = lfsr_step(seed);
		d = seed[7:0];
		s_tx <= seed[15:8];
		if (h > 2) exp_q.push_back(seed[15:8]);
		mode <= 2'(i + i / 4);
		lsb <= 1'(i / 2);
		bus_wr(2'h1, 8'(i / 4));
		bus_wr(2'h0, {2'b01, 1'(i / 2), 1'b1, 2'(i + i / 4), 2'(i)});
		bus_wr(2'h3, 8'h0d);
		#1 chk("idle", 8'(mode[1]), 8'(sck_d.o));
		gmin = 999;
		gmax = 0;
		tog = 0;
		bus_wr(2'h2, d);
		if (i == 7) bus_wr(2'h2, ~d);
		got = 8'h00;
		for (int n = 0; n < 800 && got[7] !== 1'b1; n++) bus_rd(2'h1);
		chk("stat", {1'b1, 1'(i == 7), 5'h00, 1'(i / 4)}, got);
		bus_rd(2'h2);
		if (h > 2) chk("rxbuf", exp_q.pop_front(), got);
		chk("edges", 8'h10, 8'(tog));
		chk("hmin", 8'(h), 8'(gmin));
		chk("hmax", 8'(h), 8'(gmax));
		chk("slvrx", d, s_rx);
		bus_rd(2'h1);
		chk("clear", 8'(i / 4), got);
		bus_wr(2'h3, 8'h1d);
		$display("test %0d end", i);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		bus_rd(2'h0);
		chk("ctrl", 8'h00, got);
		bus_rd(2'h1);
		chk("stat", 8'h00, got);
		bus_wr(2'h3, 8'h1d);
		bus_rd(2'h3);
		chk("pdir", 8'h1d, got);
		bus_wr(2'h0, 8'h10);
		bus_wr(2'h2, 8'h5a);
		repeat (40) @(posedge clock);
		#1 chk("off", 8'h00, 8'(tog));
		$display("test reset end");
		for (int i = 0; i < 8; i++) xfer(i);
		gie <= 1'b1;
		bus_wr(2'h3, 8'h05);
		bus_wr(2'h0, 8'hd0);
		e_ss <= 1'b0;
		repeat (8) @(posedge clock);
		bus_rd(2'h0);
		chk("fall", 8'hc0, got);
		chk("irq", 8'h01, 8'(irq));
		gie <= 1'b0;
		e_ss <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk("mask", 8'h00, 8'(irq));
		bus_wr(2'h0, 8'hd0);
		bus_rd(2'h0);
		chk("remst", 8'hd0, got);
		ack <= 1'b1;
		@(posedge clock);
		ack <= 1'b0;
		repeat (3) @(posedge clock);
		gie <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk("ack", 8'h00, 8'(irq));
		$display("test fall end");
		bus_wr(2'h0, 8'h40);
		bus_wr(2'h3, 8'h02);
		bus_wr(2'h2, 8'ha5);
		e_ss <= 1'b0;
		send(8'h3c, 3);
		e_ss <= 1'b1;
		send(8'h00, 0);
		e_ss <= 1'b0;
		send(8'h96, 8);
		#1 chk("misoe", 8'h01, 8'(miso_d.oe));
		@(posedge clock);
		e_ss <= 1'b1;
		repeat (6) @(posedge clock);
		#1 chk("misof", 8'h00, 8'(miso_d.oe));
		bus_rd(2'h1);
		chk("sdone", 8'h81, got);
		bus_rd(2'h2);
		chk("sbyte", 8'h96, got);
		chk("smiso", 8'ha5, sm);
		$display("test slave end");
		report_and_stop;
	end
endmodule
`default_nettype wire
